// ### iprv_resolver.sv
/*
  Interrupt priority resolver with vector selection, reset vectoring
  and reset cause collection. Assumes an APB master on pclk, a core
  that accepts vector and level, and raw event pulses from peripherals
  and fault detectors that are already synchronous to pclk except the
  brown-out pin, which is synchronised here.
*/
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
module iprv_resolver (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [iprv_pkg::NUM_SRC-1:0] src_event,
  input wire logic [3:0] cpu_priority_level,
  input wire logic wdt_timeout,
  input wire logic uninit_w_pointer,
  input wire logic illegal_opcode_exec,
  input wire logic illegal_opcode_flushed,
  input wire logic brownout_reset,
  input wire logic [3:0] trap_pending,
  output logic irq_req,
  output logic [6:0] irq_vector,
  output logic [2:0] irq_level,
  output logic device_reset,
  output logic [23:0] fetch_addr,
  output logic fetch_jump_target
);
  import iprv_pkg::*;

  // ==========================================================
  // Register state
  // ==========================================================
  logic [63:0] flag_reg;
  logic [63:0] enable_reg;
  logic [CAUSE_WIDTH-1:0] cause_reg;
  logic [3:0] level_reg;
  logic [15:0] pri_rd;
  logic [NUM_PRI_REGS*16-1:0] pri_words;
  logic wr_acc;
  logic rd_acc;
  logic pri_hit;
  logic [3:0] pri_idx;
  logic pend_reg;
  logic brownout_meta_reg;
  logic brownout_sync_reg;
  logic [63:0] src_mask;
  logic [63:0] flag_next;
  logic [CAUSE_WIDTH-1:0] cause_next;
  logic reset_req;
  iprv_boot_t boot_reg;

  assign src_mask = {{(64-NUM_SRC){1'b0}}, {(NUM_SRC-SRC_IMPL){1'b0}},
                     {SRC_IMPL{1'b1}}};
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  // Only aligned words inside the priority window count as hits
  assign pri_hit = paddr[1:0] == 2'b00 && paddr >= PRI_BASE &&
                   paddr < PRI_BASE + 12'(NUM_PRI_REGS * 4);
  assign pri_idx = 4'((paddr - PRI_BASE) >> 2);

  // ==========================================================
  // Priority words
  // ==========================================================
  iprv_pri_mem #(
    .DEPTH(NUM_PRI_REGS)
  ) u_pri_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && pri_hit),
    .addr(pri_idx),
    .wr_data(pwdata[15:0]),
    .rd_data(pri_rd),
    .all_words(pri_words)
  );

  // ==========================================================
  // APB slave: no wait state, one for priority reads
  // ==========================================================
  // Priority words leave the memory's read register one cycle after
  // the setup edge, so those reads answer one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (psel && !pready) begin
      pready <= penable ? pend_reg : !(rd_acc && pri_hit);
    end else begin
      pready <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      // Unaligned addresses match nothing and so are refused
      pslverr <= !(pri_hit || paddr == FLAG_BASE ||
                   paddr == FLAG_BASE + 12'h004 ||
                   paddr == ENABLE_BASE ||
                   paddr == ENABLE_BASE + 12'h004 ||
                   paddr == CPU_LEVEL_ADDR || paddr == RESULT_ADDR ||
                   paddr == CAUSE_ADDR);
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_acc) begin
      case (paddr)
        FLAG_BASE: prdata <= flag_reg[31:0];
        FLAG_BASE + 12'h004: prdata <= flag_reg[63:32];
        ENABLE_BASE: prdata <= enable_reg[31:0];
        ENABLE_BASE + 12'h004: prdata <= enable_reg[63:32];
        CPU_LEVEL_ADDR: prdata <= {28'h0000000, level_reg};
        RESULT_ADDR: prdata <= {19'h00000, irq_req,
                                1'b0, irq_level, 1'b0, irq_vector};
        CAUSE_ADDR: prdata <= {27'h0000000, cause_reg};
        default: prdata <= 32'h00000000;
      endcase
    end else if (pend_reg) begin
      prdata <= {16'h0000, pri_rd};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= rd_acc && pri_hit;
    end
  end

  // ==========================================================
  // Request flags: hardware set wins over software clear
  // ==========================================================
  always_comb begin
    flag_next = flag_reg;
    if (wr_acc && paddr == FLAG_BASE) begin
      flag_next[31:0] = pwdata;
    end
    if (wr_acc && paddr == FLAG_BASE + 12'h004) begin
      flag_next[63:32] = pwdata;
    end
    // Set regardless of enable state
    flag_next = (flag_next | {10'h000, src_event}) & src_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= {FLAG_RESET, FLAG_RESET};
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 64'h0000000000000000;
    end else if (wr_acc && paddr == ENABLE_BASE) begin
      enable_reg[31:0] <= pwdata & src_mask[31:0];
    end else if (wr_acc && paddr == ENABLE_BASE + 12'h004) begin
      enable_reg[63:32] <= pwdata & src_mask[63:32];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= CPU_LEVEL_RESET;
    end else begin
      level_reg <= cpu_priority_level;
    end
  end

  // ==========================================================
  // Resolver: highest priority, then lowest number wins
  // ==========================================================
  logic [2:0] best_pri;
  logic [5:0] best_num;
  logic best_any;
  always_comb begin
    logic [2:0] p;
    p = PRI_LOWEST;
    best_pri = PRI_LOWEST;
    best_num = 6'h00;
    best_any = 1'b0;
    // Downward scan so the lowest number is the last tie winner
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      p = pri_words[i*4 +: 3];
      // Zero priority is the same as disabled
      if (flag_reg[i] && enable_reg[i] && p != PRI_LOWEST &&
          (!best_any || p >= best_pri)) begin
        best_pri = p;
        best_num = 6'(i);
        best_any = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vector <= VECTOR_BASE;
      irq_level <= PRI_LOWEST;
    end else begin
      irq_vector <= {1'b0, best_num} + VECTOR_BASE;
      irq_level <= best_pri;
      // Reset is never arbitrated here
      irq_req <= best_any && !reset_req &&
                 {1'b0, best_pri} > cpu_priority_level;
    end
  end

  // ==========================================================
  // Reset causes and boot vectoring
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_meta_reg <= 1'b0;
      brownout_sync_reg <= 1'b0;
    end else begin
      brownout_meta_reg <= brownout_reset;
      brownout_sync_reg <= brownout_meta_reg;
    end
  end

  always_comb begin
    cause_next = '0;
    cause_next[CAUSE_WDT] = wdt_timeout;
    cause_next[CAUSE_UNINIT_W] = uninit_w_pointer;
    // Flushed opcodes never trap
    cause_next[CAUSE_ILLEGAL] = illegal_opcode_exec &&
                                !illegal_opcode_flushed;
    cause_next[CAUSE_BROWNOUT] = brownout_sync_reg;
    cause_next[CAUSE_LOCKOUT] = $countones(trap_pending) > 1;
  end
  assign reset_req = |cause_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= '0;
    end else if (reset_req) begin
      cause_reg <= cause_next;
    end else if (wr_acc && paddr == CAUSE_ADDR) begin
      cause_reg <= cause_reg & ~pwdata[CAUSE_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= reset_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= IPRV_BOOT_FETCH_JUMP;
      fetch_addr <= RESET_FETCH_ADDR;
      fetch_jump_target <= 1'b0;
    end else if (reset_req) begin
      boot_reg <= IPRV_BOOT_FETCH_JUMP;
      fetch_addr <= RESET_FETCH_ADDR;
      fetch_jump_target <= 1'b0;
    end else begin
      case (boot_reg)
        IPRV_BOOT_FETCH_JUMP: begin
          boot_reg <= IPRV_BOOT_FETCH_TARGET;
          fetch_addr <= RESET_FETCH_ADDR + 24'h000002;
          fetch_jump_target <= 1'b1;
        end
        IPRV_BOOT_FETCH_TARGET: begin
          boot_reg <= IPRV_BOOT_RUN;
          fetch_jump_target <= 1'b0;
        end
        IPRV_BOOT_RUN: begin
          fetch_jump_target <= 1'b0;
        end
        default: begin
          boot_reg <= IPRV_BOOT_FETCH_JUMP;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_flag_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    src_event[0] |=> flag_reg[0]) else $error("flag not set");
  // A zero field must never win, even when nothing else is pending
  a_zero_pri_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    best_any |-> best_pri != PRI_LOWEST) else $error("zero level won");
  a_level_above: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req |-> {1'b0, irq_level} > $past(cpu_priority_level))
    else $error("level not above cpu");
  a_vector_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req |-> irq_vector >= 7'h08 && irq_vector <= 7'h33)
    else $error("vector out of range");
  a_wdt_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    wdt_timeout |=> device_reset) else $error("no wdt reset");
  a_uninit_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    uninit_w_pointer |=> device_reset && cause_reg[CAUSE_UNINIT_W])
    else $error("no pointer reset");
  a_illegal_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    illegal_opcode_exec && !illegal_opcode_flushed |=> device_reset)
    else $error("no illegal opcode reset");
  a_flush_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    illegal_opcode_exec && illegal_opcode_flushed && !wdt_timeout &&
    !uninit_w_pointer && !brownout_sync_reg && $countones(trap_pending) < 2
    |=> !device_reset) else $error("flush reset");
  a_brownout_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    brownout_sync_reg |=> device_reset && cause_reg[CAUSE_BROWNOUT])
    else $error("no brown-out reset");
  a_lockout_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    $countones(trap_pending) > 1 |=>
    device_reset && cause_reg[CAUSE_LOCKOUT]) else $error("no lockout");
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held");
  sequence s_reset_hit;
    reset_req;
  endsequence
  sequence s_boot_pair;
    fetch_addr == RESET_FETCH_ADDR ##1 fetch_jump_target;
  endsequence
  a_boot_seq: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reset_hit ##1 !reset_req |-> s_boot_pair) else $error("boot order");
  a_no_irq_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    reset_req |=> !irq_req) else $error("reset arbitrated");
endmodule

// ### iprv_pkg.sv
/*
  Constants for the interrupt priority and vector resolver: the register
  map, field layouts, reset values and the reset-cause encoding.
  Assumes an APB slave with 32-bit data on pclk.
*/
package iprv_pkg;
  localparam int NUM_SRC = 54;
  localparam int SRC_IMPL = 44;
  localparam int NUM_REG_WORDS = 4;
  localparam int NUM_PRI_REGS = 14;
  localparam logic [5:0] FAULT_A_NUM = 6'h2A;
  localparam logic [5:0] FAULT_B_NUM = 6'h2B;
  localparam logic [6:0] VECTOR_BASE = 7'h08;
  localparam logic [2:0] PRI_LOWEST = 3'h0;
  localparam logic [2:0] PRI_HIGHEST = 3'h7;
  localparam logic [23:0] RESET_FETCH_ADDR = 24'h000000;
  localparam logic [15:0] NIBBLE_IMPL_MASK = 16'h7777;
  // Byte offsets: flags at 0x00.., enables at 0x10.., priorities 0x20..
  localparam logic [11:0] FLAG_BASE = 12'h000;
  localparam logic [11:0] ENABLE_BASE = 12'h010;
  localparam logic [11:0] PRI_BASE = 12'h020;
  localparam logic [11:0] CPU_LEVEL_ADDR = 12'h060;
  localparam logic [11:0] RESULT_ADDR = 12'h064;
  localparam logic [11:0] CAUSE_ADDR = 12'h068;
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  localparam logic [15:0] PRI_RESET = 16'h4444;
  localparam logic [3:0] CPU_LEVEL_RESET = 4'h0;
  // Reset cause bit positions
  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_UNINIT_W = 1;
  localparam int CAUSE_ILLEGAL = 2;
  localparam int CAUSE_BROWNOUT = 3;
  localparam int CAUSE_LOCKOUT = 4;
  localparam int CAUSE_WIDTH = 5;
  typedef enum logic [1:0] {
    IPRV_BOOT_FETCH_JUMP,
    IPRV_BOOT_FETCH_TARGET,
    IPRV_BOOT_RUN
  } iprv_boot_t;
endpackage

// ### iprv_pri_mem.sv
/*
  Small register array holding the priority configuration words.
  Read data leaves through a register. Assumes single-port use by the
  APB slave and a parallel view for the resolver.
*/
`timescale 1ns/10ps
module iprv_pri_mem #(
  parameter int DEPTH = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic [DEPTH*16-1:0] all_words
);
  import iprv_pkg::*;
  logic [15:0] mem_reg [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_reg[g] <= PRI_RESET;
        end else if (wr_en && addr == 4'(g)) begin
          mem_reg[g] <= wr_data & NIBBLE_IMPL_MASK;
        end
      end
      assign all_words[g*16 +: 16] = mem_reg[g];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 16'h0000;
    end else if (32'(addr) < DEPTH) begin
      rd_data <= mem_reg[addr];
    end else begin
      rd_data <= 16'h0000;
    end
  end
endmodule

// ### iprv_core_model.sv
/*
  Behavioural processor core facing the resolver: holds the current
  priority level and, when allowed to, takes the presented interrupt.
  Assumes the resolver's outputs are registered on pclk.
*/
`timescale 1ns/10ps
module iprv_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [6:0] irq_vector,
  input wire logic [2:0] irq_level,
  input wire logic [3:0] base_level,
  input wire logic take_en,
  output logic [3:0] cpu_priority_level,
  output logic [6:0] taken_vector
);
  // ==========================================================
  // Level held by the core
  // Taking an interrupt raises the level to the winner's, which
  // masks everything at or below it until the bench lowers it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_priority_level <= 4'h0;
      taken_vector <= 7'h00;
    end else if (take_en && irq_req) begin
      cpu_priority_level <= {1'b0, irq_level};
      taken_vector <= irq_vector;
    end else if (!take_en) begin
      cpu_priority_level <= base_level;
    end
  end
endmodule

// ### irq_priority_vector_resolver_tb_top.sv
/*
  Self-checking bench for the interrupt resolver: APB register access,
  source events, priority arbitration and reset causes.
  Assumes the core model file is compiled before this one.
*/
`timescale 1ns/10ps
module irq_priority_vector_resolver_tb_top;
  import iprv_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_SRC-1:0] src_event = '0;
  logic [3:0] cpu_lvl;
  logic [3:0] base_level = 4'h0;
  logic take_en = 1'b0;
  logic [6:0] taken_vector;
  logic [4:0] cause_in = 5'h00;
  logic flushed = 1'b0;
  logic irq_req;
  logic [6:0] irq_vector;
  logic [2:0] irq_level;
  logic device_reset;
  logic [23:0] fetch_addr;
  logic fetch_jt;
  logic [31:0] rd;
  logic err;
  logic seen;
  int mismatches = 0;
  int num_checks = 0;

  initial forever #2 pclk = ~pclk;

  iprv_resolver dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .cpu_priority_level(cpu_lvl),
    .wdt_timeout(cause_in[CAUSE_WDT]),
    .uninit_w_pointer(cause_in[CAUSE_UNINIT_W]),
    .illegal_opcode_exec(cause_in[CAUSE_ILLEGAL]),
    .illegal_opcode_flushed(flushed),
    .brownout_reset(cause_in[CAUSE_BROWNOUT]),
    .trap_pending({2'b00, cause_in[CAUSE_LOCKOUT], cause_in[CAUSE_LOCKOUT]}),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .device_reset(device_reset), .fetch_addr(fetch_addr),
    .fetch_jump_target(fetch_jt));

  iprv_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level),
    .base_level(base_level), .take_en(take_en),
    .cpu_priority_level(cpu_lvl), .taken_vector(taken_vector));

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request is held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [NUM_SRC-1:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= '0;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  function automatic logic [31:0] irq_word(logic r, logic [2:0] l,
                                           logic [6:0] v);
    return {21'h0, r, l, v};
  endfunction

  task automatic irq_is(input logic r, input logic [2:0] l,
                        input logic [6:0] v);
    chk(irq_word(irq_req, irq_level, irq_vector), irq_word(r, l, v));
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (15) @(posedge pclk);
    #1;
    chk(32'(fetch_addr), 32'(RESET_FETCH_ADDR));
    chk(32'(irq_vector), 32'(VECTOR_BASE));
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk({8'h00, fetch_addr}, 32'(RESET_FETCH_ADDR) + 32'h2);
    chk(32'(fetch_jt), 32'h1);
    @(posedge pclk);
    #1;
    chk(32'(fetch_jt), 32'h0);
    apb(1'b0, PRI_BASE, 32'h0);
    chk(rd, 32'(PRI_RESET));
    apb(1'b1, PRI_BASE, 32'h0000FFFF);
    apb(1'b0, PRI_BASE, 32'h0);
    chk(rd, 32'(NIBBLE_IMPL_MASK));
    apb(1'b1, PRI_BASE, 32'h00005002);
    apb(1'b1, ENABLE_BASE, 32'h00000009);
    pulse(54'h9);
    irq_is(1'b1, 3'h5, 7'h0B);
    apb(1'b1, PRI_BASE, 32'h00005005);
    repeat (2) @(posedge pclk);
    #1;
    irq_is(1'b1, 3'h5, 7'h08);
    base_level <= 4'h5;
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(irq_req), 32'h0);
    base_level <= 4'h4;
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(irq_req), 32'h1);
    base_level <= 4'h0;
    apb(1'b1, PRI_BASE, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq_req), 32'h0);
    apb(1'b1, FLAG_BASE, 32'h0);
    pulse(54'h2);
    apb(1'b0, FLAG_BASE, 32'h0);
    chk(rd, 32'h00000002);
    chk(32'(irq_req), 32'h0);
    apb(1'b1, FLAG_BASE, 32'h0);
    apb(1'b1, PRI_BASE + 12'h028, 32'h00007700);
    apb(1'b1, ENABLE_BASE + 12'h004, 32'h00000C00);
    pulse(54'h3 << FAULT_A_NUM);
    irq_is(1'b1, 3'h7, 7'h32);
    apb(1'b0, RESULT_ADDR, 32'h0);
    chk(rd, 32'h00001732);
    take_en <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(taken_vector), 32'h32);
    chk(32'(irq_req), 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, PRI_BASE + 12'h002, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    for (int i = 0; i < CAUSE_WIDTH; i++) begin
      @(posedge pclk);
      cause_in <= 5'(1 << i);
      seen = 1'b0;
      // Watch from the first edge that sees the cause, not after it
      for (int k = 0; k < 8; k++) begin
        @(posedge pclk);
        if (k == 2) begin
          cause_in <= 5'h00;
        end
        #1;
        seen |= device_reset;
      end
      chk(32'(seen), 32'h1);
      apb(1'b0, CAUSE_ADDR, 32'h0);
      chk(rd, 32'(1 << i));
      apb(1'b1, CAUSE_ADDR, 32'(1 << i));
    end
    @(posedge pclk);
    cause_in <= 5'(1 << CAUSE_ILLEGAL);
    flushed <= 1'b1;
    @(posedge pclk);
    cause_in <= 5'h00;
    flushed <= 1'b0;
    seen = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      #1;
      seen |= device_reset;
    end
    chk(32'(seen), 32'h0);
    apb(1'b0, CAUSE_ADDR, 32'h0);
    chk(rd, 32'h00000000);
    close_out();
  end
endmodule
